/* File: dv/gpb_pins_model.sv */
// Pad model: the external pins of ports B, C and D and their far side.
module gpb_pins_model (
    // Design drive
    input  wire logic [7:0]  b_out,
    input  wire logic [7:0]  b_oe,
    input  wire logic [6:0]  c_out,
    input  wire logic [6:0]  c_oe,
    input  wire logic [6:0]  c_pull,
    input  wire logic [7:0]  d_out,
    input  wire logic [7:0]  d_oe,
    // Far-side levels, reshuffled by the bench on each pass of the port loop
    input  wire logic [23:0] ext,
    // Resolved pin levels
    output logic      [7:0]  b_in,
    output logic      [6:0]  c_in,
    output logic      [7:0]  d_in
);
    // A released pin never keeps its last driven value.
    assign b_in = (b_oe & b_out) | (~b_oe & ext[7:0]);
    assign c_in = (c_oe & c_out) | (~c_oe & (c_pull | ext[14:8]));
    assign d_in = (d_oe & d_out) | (~d_oe & ext[23:16]);
endmodule : gpb_pins_model

/* File: dv/test_gpb_ports.sv */
// Self-checking bench for the general-purpose port block.
module test_gpb_ports;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0, arst_n = 1'b0;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata_q;
    logic        reg_wr, reg_rd, adc_enable, can_controller_enable;
    logic [4:0]  adc_channel_select;
    logic [7:0]  analog_input_pins_low, port_b_in, port_b_out, port_b_oe;
    logic [7:0]  port_b_level, port_d_in, port_d_out, port_d_oe;
    logic [7:0]  port_d_level;
    logic [6:0]  port_c_in, port_c_out, port_c_oe, port_c_pullup;
    logic [6:0]  port_c_level;
    logic        can_transmit_pin, can_receive_pin, serial_peripheral_enable;
    logic        serial_peripheral_master, clock_out_enable, clock_out_level;
    logic [3:0]  first_timer_edge_level_select, second_timer_edge_level_select;
    logic [1:0]  first_timer_pin_out, first_timer_pin_oe;
    logic [1:0]  second_timer_pin_out, second_timer_pin_oe;
    logic [3:0]  serial_peripheral_pin_out, serial_peripheral_pin_oe;
    logic [23:0] ext;
    logic [31:0] lfsr = 32'h1A14E6F3;
    int          mismatches = 0, n_compared = 0, cycles = 0;
    wire  [23:0] all_oe = {port_d_oe, 1'b0, port_c_oe, port_b_oe};
    wire  [23:0] all_out = {port_d_out, 1'b0, port_c_out, port_b_out};
    wire  [23:0] all_lvl = {port_d_level, 1'b0, port_c_level, port_b_level};

    gpb_ports i_dut (.*);
    gpb_pins_model i_pins (.b_out(port_b_out), .b_oe(port_b_oe),
        .c_out(port_c_out), .c_oe(port_c_oe), .c_pull(port_c_pullup),
        .d_out(port_d_out), .d_oe(port_d_oe), .ext(ext),
        .b_in(port_b_in), .c_in(port_c_in), .d_in(port_d_in));

    always #50 sys_clk = ~sys_clk;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction : rnd
    function automatic logic [7:0] exp_rd(input logic [7:0] dir, lat, pin);
        return (dir & lat) | (~dir & pin);
    endfunction : exp_rd
    task automatic chk(input logic [7:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_q;
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : idle
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    // Roughly 230 cycles are needed; the ceiling leaves ample margin.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            test_done();
        end
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        logic [7:0] r, d, m;
        logic [7:0] lat [1:3];
        {reg_addr, reg_wdata, reg_wr, reg_rd, adc_enable} = '0;
        {adc_channel_select, can_controller_enable, can_transmit_pin} = '0;
        {serial_peripheral_enable, serial_peripheral_master} = '0;
        {clock_out_enable, clock_out_level, first_timer_pin_out} = '0;
        {first_timer_pin_oe, second_timer_pin_out, second_timer_pin_oe} = '0;
        {first_timer_edge_level_select, second_timer_edge_level_select} = '0;
        {serial_peripheral_pin_out, serial_peripheral_pin_oe} = '0;
        ext = 24'h5A3C96;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int i = 4; i < 8; i++) begin
            rd(8'(i), r);
            chk(r, 8'h00);
        end
        for (int k = 0; k < 9; k++) begin
            int p;
            p = k % 3 + 1;
            m = (p == 2) ? 8'h7F : 8'hFF;
            @(posedge sys_clk);
            ext <= {rnd(), rnd(), rnd()};
            lat[p] = rnd();
            d = rnd() & m;
            wr(8'(p), lat[p]);
            wr(8'(p + 4), d);
            idle(6);
            rd(8'(p), r);
            m = exp_rd(d, lat[p], ext[8*p-8 +: 8]) & m;
            chk(r, m);
            chk(all_lvl[8*p-8 +: 8], m);
            chk(all_oe[8*p-8 +: 8], d);
            chk(all_out[8*p-8 +: 8] & d, lat[p] & d);
        end
        @(posedge sys_clk);
        arst_n <= 1'b0;
        idle(2);
        chk(port_b_oe, 8'h00);
        @(posedge sys_clk);
        arst_n <= 1'b1;
        wr(8'h05, 8'hFF);
        rd(8'h01, r);
        chk(r, lat[1]);
        for (int ch = 0; ch < 8; ch++) begin
            @(posedge sys_clk);
            adc_enable <= 1'b1;
            adc_channel_select <= 5'(ch);
            idle(3);
            chk(analog_input_pins_low, 8'h01 << ch);
            chk(port_b_oe, ~(8'h01 << ch));
        end
        wr(8'h06, 8'h7F);
        for (int t = 0; t < 3; t++) begin
            @(posedge sys_clk);
            adc_enable <= 1'b0;
            can_controller_enable <= (t < 2);
            can_transmit_pin <= t[0];
            ext[9] <= ~t[0];
            idle(6);
            r = (t < 2) ? {5'h00, 2'b01, t[0]} : {5'h00, 2'b11, lat[2][0]};
            chk({5'h00, port_c_oe[1:0], port_c_out[0]}, r);
            chk({7'h00, can_receive_pin}, {7'h00, ~t[0] | t[1]});
        end
        wr(8'h0C, 8'hFF);
        wr(8'h06, 8'h0F);
        idle(3);
        chk({1'b0, port_c_pullup}, 8'h70);
        rd(8'h0C, r);
        chk(r, 8'h7F);
        wr(8'h07, 8'h08);
        @(posedge sys_clk);
        first_timer_edge_level_select <= 4'h5;
        second_timer_edge_level_select <= 4'hA;
        d = rnd();
        {first_timer_pin_out, first_timer_pin_oe} <= d[3:0];
        {second_timer_pin_out, second_timer_pin_oe} <= d[7:4];
        clock_out_enable <= 1'b1;
        clock_out_level <= d[0];
        idle(3);
        m = {d[1:0], d[5:4], 4'h9};
        chk(port_d_oe, m);
        chk(port_d_out & m, {d[3:2], d[7:6], lat[3][3], 2'b00, d[0]} & m);
        @(posedge sys_clk);
        serial_peripheral_enable <= 1'b1;
        serial_peripheral_master <= 1'b1;
        serial_peripheral_pin_oe <= 4'hE;
        d = rnd();
        serial_peripheral_pin_out <= d[3:0];
        idle(6);
        chk({4'h0, port_d_oe[3:0]}, 8'h0F);
        rd(8'h03, r);
        chk(r & 8'h0E, exp_rd(8'h08, lat[3], {4'h0, d[3:0]}) & 8'h0E);
        wr(8'h07, 8'hFF);
        @(posedge sys_clk);
        reg_addr <= 8'h03;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata_q, d);
        test_done();
    end
endmodule : test_gpb_ports

/* File: rtl/gpb_consts.svh */
// Offsets, bit positions and reset values of the general-purpose ports.
`ifndef GPB_CONSTS_SVH
`define GPB_CONSTS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define GPB_OFF_B_DATA  8'h01
`define GPB_OFF_C_DATA  8'h02
`define GPB_OFF_D_DATA  8'h03
`define GPB_OFF_B_DIR   8'h05
`define GPB_OFF_C_DIR   8'h06
`define GPB_OFF_D_DIR   8'h07
`define GPB_OFF_C_PUE   8'h0C

// ************************************************************
// Reset values
// ************************************************************
`define GPB_B_DIR_RST   8'h00
`define GPB_C_DIR_RST   7'h00
`define GPB_D_DIR_RST   8'h00
`define GPB_C_PUE_RST   7'h00
`define GPB_RD_IDLE     8'h00
`define GPB_PAD_C       1'h0
`define GPB_CAN_IDLE    1'h1

// ************************************************************
// Shared pin positions and peripheral encodings
// ************************************************************
`define GPB_CAN_TX_BIT  0
`define GPB_CAN_RX_BIT  1
`define GPB_SPI_SS_BIT  0
`define GPB_SPI_SCK_BIT 3
`define GPB_CLKOUT_BIT  0
`define GPB_T2_BASE     4
`define GPB_T1_BASE     6
`define GPB_ADC_B_CHANS 5'h08
`define GPB_ELS_OFF     2'h0

`endif

/* File: rtl/gpb_pin_drive.sv */
// Registered pin driver for one port: direction, override, pullup.
module gpb_pin_drive #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    // Port state
    input  wire logic [WIDTH-1:0] latch,
    input  wire logic [WIDTH-1:0] dir,
    input  wire logic [WIDTH-1:0] pue,
    // Peripheral override
    input  wire logic [WIDTH-1:0] ovr_en,
    input  wire logic [WIDTH-1:0] ovr_out,
    input  wire logic [WIDTH-1:0] ovr_oe,
    // Pin side
    output logic      [WIDTH-1:0] pin_out_q,
    output logic      [WIDTH-1:0] pin_oe_q,
    output logic      [WIDTH-1:0] pin_pull_q
);

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic oe_d;
        assign oe_d = ovr_en[i] ? ovr_oe[i] : dir[i];

        // Latch contents of unwritten pins stay invisible until driven.
        always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
                pin_oe_q[i]   <= 1'b0;
                pin_out_q[i]  <= 1'b0;
                pin_pull_q[i] <= 1'b0;
            end else begin
                pin_oe_q[i]   <= oe_d;
                pin_out_q[i]  <= oe_d & (ovr_en[i] ? ovr_out[i]
                                                   : latch[i]);
                pin_pull_q[i] <= ~ovr_en[i] & ~dir[i] & pue[i];
            end
        end
    end

endmodule : gpb_pin_drive

/* File: rtl/gpb_pkg.sv */
// Types shared by the general-purpose port block.
package gpb_pkg;

    typedef enum {
        sel_none,
        sel_b_data,
        sel_c_data,
        sel_d_data,
        sel_b_dir,
        sel_c_dir,
        sel_d_dir,
        sel_c_pue
    } gpb_reg_sel_type;

endpackage : gpb_pkg

/* File: rtl/gpb_ports.sv */
// General-purpose ports B, C and D with register port and pin sharing.
//
// The implementer's own choice: strobed register access.
`include "gpb_consts.svh"

// Function
// - Reset leaves all data latches untouched.
// - Direction one drives pin, zero releases.
// - Reset clears every direction bit.
// - Port B read: latch if output, else pin.
// - Latch writes always accepted, input pins unaffected.
// - Selected ADC channel takes its port B pin.
// - Port C has seven pins, two CAN-shareable.
// - CAN enable takes port C low pins.
// - Port C read: latch if output, else pin.
// - Port C pullup follows its enable bit.
// - Output direction always switches pullup off.
// - Port D eight pins, lowest carries clock out.
// - First timer select claims upper port D pins.
// - Second timer select claims its port D pins.
// - SPI disabled leaves serial clock pin general.
// - Port D read: latch if output, else pin.
// - SPI pins ignore direction, read still uses it.
module gpb_ports (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata_q,
    // Analog converter
    input  wire logic       adc_enable,
    input  wire logic [4:0] adc_channel_select,
    output logic      [7:0] analog_input_pins_low,
    // CAN controller
    input  wire logic       can_controller_enable,
    input  wire logic       can_transmit_pin,
    output logic            can_receive_pin,
    // Timers
    input  wire logic [3:0] first_timer_edge_level_select,
    input  wire logic [1:0] first_timer_pin_out,
    input  wire logic [1:0] first_timer_pin_oe,
    input  wire logic [3:0] second_timer_edge_level_select,
    input  wire logic [1:0] second_timer_pin_out,
    input  wire logic [1:0] second_timer_pin_oe,
    // Serial peripheral and clock output
    input  wire logic       serial_peripheral_enable,
    input  wire logic       serial_peripheral_master,
    input  wire logic [3:0] serial_peripheral_pin_out,
    input  wire logic [3:0] serial_peripheral_pin_oe,
    input  wire logic       clock_out_enable,
    input  wire logic       clock_out_level,
    // Port B pins
    input  wire logic [7:0] port_b_in,
    output logic      [7:0] port_b_out,
    output logic      [7:0] port_b_oe,
    output logic      [7:0] port_b_level,
    // Port C pins
    input  wire logic [6:0] port_c_in,
    output logic      [6:0] port_c_out,
    output logic      [6:0] port_c_oe,
    output logic      [6:0] port_c_pullup,
    output logic      [6:0] port_c_level,
    // Port D pins
    input  wire logic [7:0] port_d_in,
    output logic      [7:0] port_d_out,
    output logic      [7:0] port_d_oe,
    output logic      [7:0] port_d_level
);

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic gpb_pkg::gpb_reg_sel_type reg_decode(
        input logic [7:0] addr
    );
        case (addr)
            `GPB_OFF_B_DATA: reg_decode = gpb_pkg::sel_b_data;
            `GPB_OFF_C_DATA: reg_decode = gpb_pkg::sel_c_data;
            `GPB_OFF_D_DATA: reg_decode = gpb_pkg::sel_d_data;
            `GPB_OFF_B_DIR:  reg_decode = gpb_pkg::sel_b_dir;
            `GPB_OFF_C_DIR:  reg_decode = gpb_pkg::sel_c_dir;
            `GPB_OFF_D_DIR:  reg_decode = gpb_pkg::sel_d_dir;
            `GPB_OFF_C_PUE:  reg_decode = gpb_pkg::sel_c_pue;
            default:         reg_decode = gpb_pkg::sel_none;
        endcase
    endfunction : reg_decode

    // Output pins read back their latch, input pins their level.
    function automatic logic [7:0] port_read(
        input logic [7:0] dir,
        input logic [7:0] latch,
        input logic [7:0] level
    );
        port_read = (dir & latch) | (~dir & level);
    endfunction : port_read

    gpb_pkg::gpb_reg_sel_type sel;
    assign sel = reg_decode(reg_addr);

    // ************************************************************
    // Data latches
    // ************************************************************
    logic [7:0] port_b_data_latch_q;
    logic [6:0] port_c_data_latch_q;
    logic [7:0] port_d_data_latch_q;

    // No reset branch: the latches keep their value through reset.
    always_ff @(posedge sys_clk) begin
        if (reg_wr && sel == gpb_pkg::sel_b_data) begin
            port_b_data_latch_q <= reg_wdata;
        end
        if (reg_wr && sel == gpb_pkg::sel_c_data) begin
            port_c_data_latch_q <= reg_wdata[6:0];
        end
        if (reg_wr && sel == gpb_pkg::sel_d_data) begin
            port_d_data_latch_q <= reg_wdata;
        end
    end

    // ************************************************************
    // Direction and pullup registers
    // ************************************************************
    logic [7:0] port_b_direction_q;
    logic [6:0] port_c_direction_q;
    logic [7:0] port_d_direction_q;
    logic [6:0] port_c_pullup_enable_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            port_b_direction_q <= `GPB_B_DIR_RST;
            port_c_direction_q <= `GPB_C_DIR_RST;
            port_d_direction_q <= `GPB_D_DIR_RST;
        end else if (reg_wr) begin
            if (sel == gpb_pkg::sel_b_dir) begin
                port_b_direction_q <= reg_wdata;
            end
            if (sel == gpb_pkg::sel_c_dir) begin
                port_c_direction_q <= reg_wdata[6:0];
            end
            if (sel == gpb_pkg::sel_d_dir) begin
                port_d_direction_q <= reg_wdata;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            port_c_pullup_enable_q <= `GPB_C_PUE_RST;
        end else if (reg_wr && sel == gpb_pkg::sel_c_pue) begin
            port_c_pullup_enable_q <= reg_wdata[6:0];
        end
    end

    // ************************************************************
    // Pin input synchronisers
    // ************************************************************
    gpb_sync #(.WIDTH(8)) u_sync_b (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .pin_in  (port_b_in),
        .level_q (port_b_level)
    );

    gpb_sync #(.WIDTH(7)) u_sync_c (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .pin_in  (port_c_in),
        .level_q (port_c_level)
    );

    gpb_sync #(.WIDTH(8)) u_sync_d (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .pin_in  (port_d_in),
        .level_q (port_d_level)
    );

    // ************************************************************
    // Peripheral overrides
    // ************************************************************
    logic [7:0] b_ana_mask;
    logic [6:0] c_ovr_en;
    logic [6:0] c_ovr_out;
    logic [6:0] c_ovr_oe;
    logic [7:0] d_ovr_en;
    logic [7:0] d_ovr_out;
    logic [7:0] d_ovr_oe;

    // Only channels below the port B count land on these pins.
    always_comb begin
        b_ana_mask = '0;
        if (adc_enable && adc_channel_select < `GPB_ADC_B_CHANS) begin
            b_ana_mask = 8'h01 << adc_channel_select[2:0];
        end
    end

    always_comb begin
        c_ovr_en  = '0;
        c_ovr_out = '0;
        c_ovr_oe  = '0;
        if (can_controller_enable) begin
            c_ovr_en[`GPB_CAN_TX_BIT]  = 1'b1;
            c_ovr_oe[`GPB_CAN_TX_BIT]  = 1'b1;
            c_ovr_out[`GPB_CAN_TX_BIT] = can_transmit_pin;
            c_ovr_en[`GPB_CAN_RX_BIT]  = 1'b1;
        end
    end

    // The clock output outranks the slave-select input on the lowest pin.
    always_comb begin
        d_ovr_en  = '0;
        d_ovr_out = '0;
        d_ovr_oe  = '0;
        for (int i = 0; i < 2; i++) begin
            if (second_timer_edge_level_select[2*i +: 2]
                    != `GPB_ELS_OFF) begin
                d_ovr_en[`GPB_T2_BASE + i]  = 1'b1;
                d_ovr_out[`GPB_T2_BASE + i] = second_timer_pin_out[i];
                d_ovr_oe[`GPB_T2_BASE + i]  = second_timer_pin_oe[i];
            end
            if (first_timer_edge_level_select[2*i +: 2]
                    != `GPB_ELS_OFF) begin
                d_ovr_en[`GPB_T1_BASE + i]  = 1'b1;
                d_ovr_out[`GPB_T1_BASE + i] = first_timer_pin_out[i];
                d_ovr_oe[`GPB_T1_BASE + i]  = first_timer_pin_oe[i];
            end
        end
        if (serial_peripheral_enable) begin
            for (int i = `GPB_SPI_SS_BIT + 1;
                 i <= `GPB_SPI_SCK_BIT; i++) begin
                d_ovr_en[i]  = 1'b1;
                d_ovr_out[i] = serial_peripheral_pin_out[i];
                d_ovr_oe[i]  = serial_peripheral_pin_oe[i];
            end
            if (!serial_peripheral_master) begin
                d_ovr_en[`GPB_SPI_SS_BIT]  = 1'b1;
                d_ovr_out[`GPB_SPI_SS_BIT] = 1'b0;
                d_ovr_oe[`GPB_SPI_SS_BIT]  = 1'b0;
            end
        end
        if (clock_out_enable) begin
            d_ovr_en[`GPB_CLKOUT_BIT]  = 1'b1;
            d_ovr_out[`GPB_CLKOUT_BIT] = clock_out_level;
            d_ovr_oe[`GPB_CLKOUT_BIT]  = 1'b1;
        end
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    gpb_pin_drive #(.WIDTH(8)) u_drive_b (
        .sys_clk    (sys_clk),
        .arst_n     (arst_n),
        .latch      (port_b_data_latch_q),
        .dir        (port_b_direction_q),
        .pue        (8'h00),
        .ovr_en     (b_ana_mask),
        .ovr_out    (8'h00),
        .ovr_oe     (8'h00),
        .pin_out_q  (port_b_out),
        .pin_oe_q   (port_b_oe),
        .pin_pull_q ()
    );

    gpb_pin_drive #(.WIDTH(7)) u_drive_c (
        .sys_clk    (sys_clk),
        .arst_n     (arst_n),
        .latch      (port_c_data_latch_q),
        .dir        (port_c_direction_q),
        .pue        (port_c_pullup_enable_q),
        .ovr_en     (c_ovr_en),
        .ovr_out    (c_ovr_out),
        .ovr_oe     (c_ovr_oe),
        .pin_out_q  (port_c_out),
        .pin_oe_q   (port_c_oe),
        .pin_pull_q (port_c_pullup)
    );

    gpb_pin_drive #(.WIDTH(8)) u_drive_d (
        .sys_clk    (sys_clk),
        .arst_n     (arst_n),
        .latch      (port_d_data_latch_q),
        .dir        (port_d_direction_q),
        .pue        (8'h00),
        .ovr_en     (d_ovr_en),
        .ovr_out    (d_ovr_out),
        .ovr_oe     (d_ovr_oe),
        .pin_out_q  (port_d_out),
        .pin_oe_q   (port_d_oe),
        .pin_pull_q ()
    );

    // ************************************************************
    // Peripheral-facing outputs
    // ************************************************************
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            analog_input_pins_low <= '0;
            can_receive_pin       <= `GPB_CAN_IDLE;
        end else begin
            analog_input_pins_low <= b_ana_mask;
            can_receive_pin       <= can_controller_enable
                                   ? port_c_level[`GPB_CAN_RX_BIT]
                                   : `GPB_CAN_IDLE;
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_q <= `GPB_RD_IDLE;
        end else if (!reg_rd) begin
            reg_rdata_q <= `GPB_RD_IDLE;
        end else begin
            unique case (sel)
                gpb_pkg::sel_b_data: reg_rdata_q <= port_read(
                    port_b_direction_q, port_b_data_latch_q, port_b_level);
                gpb_pkg::sel_c_data: reg_rdata_q <= port_read(
                    {`GPB_PAD_C, port_c_direction_q},
                    {`GPB_PAD_C, port_c_data_latch_q},
                    {`GPB_PAD_C, port_c_level});
                gpb_pkg::sel_d_data: reg_rdata_q <= port_read(
                    port_d_direction_q, port_d_data_latch_q, port_d_level);
                gpb_pkg::sel_b_dir:  reg_rdata_q <= port_b_direction_q;
                gpb_pkg::sel_c_dir:
                    reg_rdata_q <= {`GPB_PAD_C, port_c_direction_q};
                gpb_pkg::sel_d_dir:  reg_rdata_q <= port_d_direction_q;
                gpb_pkg::sel_c_pue:
                    reg_rdata_q <= {`GPB_PAD_C, port_c_pullup_enable_q};
                gpb_pkg::sel_none:   reg_rdata_q <= `GPB_RD_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_rd(logic [7:0] off);
        reg_rd && reg_addr == off;
    endsequence

    sequence s_wr(logic [7:0] off);
        reg_wr && reg_addr == off;
    endsequence

    property p_dir_reset;
        $rose(arst_n) |-> port_b_direction_q == 8'h00
            && port_c_direction_q == 7'h00 && port_d_direction_q == 8'h00
            && port_b_oe == 8'h00;
    endproperty
    a_dir_reset: assert property (p_dir_reset)
        else $error("direction bits not cleared by reset");

    property p_b_oe;
        1 |=> port_b_oe == $past(port_b_direction_q & ~b_ana_mask);
    endproperty
    a_b_oe: assert property (p_b_oe)
        else $error("port B enable does not follow direction");

    property p_b_read;
        s_rd(`GPB_OFF_B_DATA) |=> reg_rdata_q == (($past(port_b_direction_q)
            & $past(port_b_data_latch_q))
            | (~$past(port_b_direction_q) & $past(port_b_level)));
    endproperty
    a_b_read: assert property (p_b_read)
        else $error("port B read mixes latch and pin wrongly");

    property p_latch_write;
        s_wr(`GPB_OFF_D_DATA) ##1 (s_rd(`GPB_OFF_D_DATA)
            and port_d_direction_q == 8'hFF)
            |=> reg_rdata_q == $past(reg_wdata, 2);
    endproperty
    a_latch_write: assert property (p_latch_write)
        else $error("port D latch write lost");

    property p_adc_take;
        adc_enable && adc_channel_select == 5'h03
            |=> analog_input_pins_low[3] && !port_b_oe[3];
    endproperty
    a_adc_take: assert property (p_adc_take)
        else $error("selected analog pin still driven");

    property p_can_take;
        can_controller_enable |=> !port_c_oe[1] && port_c_oe[0]
            && port_c_out[0] == $past(can_transmit_pin);
    endproperty
    a_can_take: assert property (p_can_take)
        else $error("CAN pins not handed over");

    property p_pull_on;
        port_c_pullup_enable_q[6] && !port_c_direction_q[6]
            |=> port_c_pullup[6];
    endproperty
    a_pull_on: assert property (p_pull_on)
        else $error("enabled input pullup missing");

    property p_pull_off;
        (port_c_pullup & port_c_oe) == 7'h00;
    endproperty
    a_pull_off: assert property (p_pull_off)
        else $error("pullup left on a driven pin");

    property p_timer1;
        first_timer_edge_level_select[3:2] != `GPB_ELS_OFF
            |=> port_d_oe[7] == $past(first_timer_pin_oe[1]);
    endproperty
    a_timer1: assert property (p_timer1)
        else $error("first timer does not own upper pin");

    property p_sck_free;
        !serial_peripheral_enable |=> port_d_oe[3]
            == $past(port_d_direction_q[3]);
    endproperty
    a_sck_free: assert property (p_sck_free)
        else $error("serial clock pin not general-purpose");

    property p_c_top;
        s_rd(`GPB_OFF_C_DATA) or s_rd(`GPB_OFF_C_DIR)
            or s_rd(`GPB_OFF_C_PUE) |=> !reg_rdata_q[7];
    endproperty
    a_c_top: assert property (p_c_top)
        else $error("port C top bit reads one");

endmodule : gpb_ports

/* File: rtl/gpb_sync.sv */
// Three-stage pin input synchroniser with agreement filter.
module gpb_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    // Pins and filtered level
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_q
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit only moves once two later stages agree, which hides a
    // single-cycle metastable settle.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            level_q <= '0;
        end else begin
            level_q <= (s2_q & ~(s2_q ^ s3_q)) | (level_q & (s2_q ^ s3_q));
        end
    end

endmodule : gpb_sync
